// ### pges_regs.svh
// Register offsets, field positions and reset values of the event pin status and control bank.
// Included by the bank and the testbench; it holds definitions only.
`ifndef PGES_REGS_SVH
`define PGES_REGS_SVH

// ----------------------------------------
// Offsets
// ----------------------------------------
`define PGES_UNIT_INDEX_OFS   12'h0520
`define PGES_IRQ_STATUS_OFS   12'h0528
`define PGES_CTRL_STATUS_OFS  12'h052C
`define PGES_IRQ_ENABLE_OFS   12'h0540
`define PGES_IRQ_CLEAR_OFS    12'h0544
`define PGES_OU_ENABLE_OFS    12'h0548

// ----------------------------------------
// Field positions
// ----------------------------------------
`define PGES_OU_PTR_LSB       0
`define PGES_CU_PTR_BIT       8
`define PGES_PIN_PTR_BIT      16
`define PGES_OU_STAT_LSB      16
`define PGES_CU_STAT_LSB      0
`define PGES_CS_OUT_SEL_BIT   8
`define PGES_CS_PIN_IN_BIT    7
`define PGES_CS_DIR_BIT       6
`define PGES_CS_CU_IRQ_BIT    5
`define PGES_CS_OU_ACT_BIT    4
`define PGES_EN_OU_NOTIFY_LSB 0
`define PGES_EN_OU_RUN_LSB    4

// ----------------------------------------
// Reset values and the reserved unit pointer
// ----------------------------------------
`define PGES_OU_STAT_RST      3'h0
`define PGES_CU_STAT_RST      2'h0
`define PGES_OU_PTR_RESERVED  2'h3

`endif

// ### pges_pkg.sv
// Types shared by the event pin status and control bank.
// Assumes the header of offsets is on the include path.
package pges_pkg;
	typedef logic [11:0] pges_addr_type;
	typedef logic [31:0] pges_word_type;
	typedef enum logic [2:0] {
		PGES_OU_IDLE = 3'b001,
		PGES_OU_RUN  = 3'b010,
		PGES_OU_DONE = 3'b100
	} pges_ou_state_type;
endpackage

// ### pges_sync.sv
// Two flip-flop synchroniser for pin levels.
// Assumes the inputs are asynchronous to sys_clk.
`timescale 1ns/10ps
`default_nettype none
module pges_sync #(
	parameter int W = 2
) (
	// Clock and reset
	input  wire logic         sys_clk,
	input  wire logic         nrst,
	// Levels
	input  wire logic [W-1:0] async_in,
	output logic      [W-1:0] sync_out
);
	logic [W-1:0] meta_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			meta_q   <= '0;
			sync_out <= '0;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ### pges_out_unit.sv
// One event output unit: runs while enabled, reports fire and late alike as one event pulse.
// Assumes the timing engine outside reports fire and late as one-cycle pulses.
`timescale 1ns/10ps
`default_nettype none
module pges_out_unit (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic nrst,
	// Control
	input  wire logic enable,
	input  wire logic fire,
	input  wire logic late,
	// Status
	output logic      active,
	output logic      event_pulse
);
	import pges_pkg::*;

	pges_ou_state_type state_q;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q     <= PGES_OU_IDLE;
			event_pulse <= 1'b0;
		end else begin
			event_pulse <= 1'b0;
			case (state_q)
				PGES_OU_IDLE: begin
					if (enable) begin
						state_q <= PGES_OU_RUN;
					end
				end
				PGES_OU_RUN: begin
					if (!enable) begin
						state_q <= PGES_OU_IDLE;
					end else if (fire || late) begin
						state_q     <= PGES_OU_DONE;
						event_pulse <= 1'b1;
					end
				end
				PGES_OU_DONE: begin
					if (!enable) begin
						state_q <= PGES_OU_IDLE;
					end
				end
				default: state_q <= PGES_OU_IDLE;
			endcase
		end
	end

	assign active = (state_q == PGES_OU_RUN);
endmodule
`default_nettype wire

// ### pges_bank.sv
// Status and control bank for the precision-time event pins.
// Assumes a single-cycle register port master and outside unit timing engines.
//
// Our own choice: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "pges_regs.svh"

module pges_bank (
	// Clock and reset
	input  wire logic                   sys_clk,
	input  wire logic                   nrst,
	// Register port
	input  wire pges_pkg::pges_addr_type reg_addr,
	input  wire pges_pkg::pges_word_type reg_wdata,
	input  wire logic                   reg_wr,
	input  wire logic                   reg_rd,
	output var pges_pkg::pges_word_type  reg_rdata,
	// Unit events from timing engines
	input  wire logic [2:0]             ou_fire,
	input  wire logic [2:0]             ou_late,
	input  wire logic [1:0]             cu_pin_event,
	// Pins
	input  wire logic [1:0]             pin_in,
	input  wire logic [1:0]             ou_pin_level,
	output logic      [1:0]             pin_out,
	output logic      [1:0]             pin_oe,
	// Interrupt
	output logic                        irq
);
	import pges_pkg::*;

	// ----------------------------------------
	// Decode helpers
	// ----------------------------------------
	function automatic logic hit(input pges_addr_type a, input pges_addr_type ofs);
		return a == ofs;
	endfunction

	function automatic logic [2:0] ou_onehot(input logic [1:0] ptr);
		if (ptr == `PGES_OU_PTR_RESERVED) begin
			return 3'h0;
		end else begin
			return 3'(3'h1 << ptr);
		end
	endfunction

	// ----------------------------------------
	// State
	// ----------------------------------------
	logic [1:0] ou_ptr_q;
	logic       cu_ptr_q;
	logic       pin_ptr_q;
	logic [2:0] ou_stat_q;
	logic [1:0] cu_stat_q;
	logic [2:0] ou_notify_q;
	logic [2:0] ou_run_q;
	logic [1:0] cu_irq_en_q;
	logic [1:0] pin_dir_q;
	logic [1:0] out_sel_q;
	logic [1:0] pin_flop_q;
	logic [4:0] irq_en_q;
	logic [1:0] pin_sync;
	logic [2:0] ou_active;
	logic [2:0] ou_event;
	logic [2:0] ou_sel;
	logic       wr_idx;
	logic       wr_cs;
	logic       wr_clr;
	logic [2:0] ou_clr;
	logic [1:0] cu_clr;
	logic [2:0] ou_set;
	logic [1:0] cu_set;
	logic [4:0] stat_all;
	pges_word_type rd_d;

	assign ou_sel = ou_onehot(ou_ptr_q);
	assign wr_idx = reg_wr && hit(reg_addr, `PGES_UNIT_INDEX_OFS);
	assign wr_cs  = reg_wr && hit(reg_addr, `PGES_CTRL_STATUS_OFS);
	assign wr_clr = reg_wr && (hit(reg_addr, `PGES_IRQ_STATUS_OFS)
		|| hit(reg_addr, `PGES_IRQ_CLEAR_OFS));

	// ----------------------------------------
	// Submodules
	// ----------------------------------------
	pges_sync #(.W(2)) u_sync (
		.sys_clk  (sys_clk),
		.nrst     (nrst),
		.async_in (pin_in),
		.sync_out (pin_sync)
	);

	for (genvar i = 0; i < 3; i++) begin : g_ou
		pges_out_unit u_ou (
			.sys_clk     (sys_clk),
			.nrst        (nrst),
			.enable      (ou_run_q[i]),
			.fire        (ou_fire[i]),
			.late        (ou_late[i]),
			.active      (ou_active[i]),
			.event_pulse (ou_event[i])
		);
	end

	// ----------------------------------------
	// Index and control writes
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ou_ptr_q  <= 2'h0;
			cu_ptr_q  <= 1'b0;
			pin_ptr_q <= 1'b0;
		end else if (wr_idx) begin
			ou_ptr_q  <= reg_wdata[`PGES_OU_PTR_LSB +: 2];
			cu_ptr_q  <= reg_wdata[`PGES_CU_PTR_BIT];
			pin_ptr_q <= reg_wdata[`PGES_PIN_PTR_BIT];
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cu_irq_en_q <= 2'h0;
			pin_dir_q   <= 2'h0;
			out_sel_q   <= 2'h0;
		end else if (wr_cs) begin
			cu_irq_en_q[cu_ptr_q] <= reg_wdata[`PGES_CS_CU_IRQ_BIT];
			pin_dir_q[pin_ptr_q]  <= reg_wdata[`PGES_CS_DIR_BIT];
			out_sel_q[pin_ptr_q]  <= reg_wdata[`PGES_CS_OUT_SEL_BIT];
		end
	end

	// Run enables self-clear once the unit leaves its running state
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ou_notify_q <= 3'h0;
			ou_run_q    <= 3'h0;
			irq_en_q    <= 5'h1F;
		end else begin
			ou_run_q <= ou_run_q & ~ou_event;
			if (reg_wr && hit(reg_addr, `PGES_OU_ENABLE_OFS)) begin
				ou_notify_q <= reg_wdata[`PGES_EN_OU_NOTIFY_LSB +: 3];
				ou_run_q    <= reg_wdata[`PGES_EN_OU_RUN_LSB +: 3];
			end
			if (reg_wr && hit(reg_addr, `PGES_IRQ_ENABLE_OFS)) begin
				irq_en_q <= {reg_wdata[`PGES_OU_STAT_LSB +: 3], reg_wdata[`PGES_CU_STAT_LSB +: 2]};
			end
		end
	end

	// ----------------------------------------
	// Sticky status, set wins over clear
	// ----------------------------------------
	assign ou_set = ou_event & ou_notify_q;
	assign cu_set = cu_pin_event & cu_irq_en_q;
	assign ou_clr = wr_clr ? reg_wdata[`PGES_OU_STAT_LSB +: 3] : 3'h0;
	assign cu_clr = wr_clr ? reg_wdata[`PGES_CU_STAT_LSB +: 2] : 2'h0;

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ou_stat_q <= `PGES_OU_STAT_RST;
			cu_stat_q <= `PGES_CU_STAT_RST;
		end else begin
			ou_stat_q <= (ou_stat_q & ~ou_clr) | ou_set;
			cu_stat_q <= (cu_stat_q & ~cu_clr) | cu_set;
		end
	end

	assign stat_all = {ou_stat_q, cu_stat_q};

	// Summary interrupt, enable-gated for the outside controller
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			irq <= 1'b0;
		end else begin
			irq <= |(((stat_all & ~{ou_clr, cu_clr}) | {ou_set, cu_set}) & irq_en_q);
		end
	end

	// ----------------------------------------
	// Pins
	// ----------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			pin_flop_q <= 2'h0;
			pin_out    <= 2'h0;
			pin_oe     <= 2'h0;
		end else begin
			pin_flop_q <= ou_pin_level;
			for (int i = 0; i < 2; i++) begin
				// Combinational path saves one cycle of latency
				pin_out[i] <= out_sel_q[i] ? ou_pin_level[i] : pin_flop_q[i];
				pin_oe[i]  <= !pin_dir_q[i];
			end
		end
	end

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_comb begin
		rd_d = 32'h0000_0000;
		if (hit(reg_addr, `PGES_UNIT_INDEX_OFS)) begin
			rd_d[`PGES_OU_PTR_LSB +: 2] = ou_ptr_q;
			rd_d[`PGES_CU_PTR_BIT]      = cu_ptr_q;
			rd_d[`PGES_PIN_PTR_BIT]     = pin_ptr_q;
		end else if (hit(reg_addr, `PGES_IRQ_STATUS_OFS)) begin
			rd_d[`PGES_OU_STAT_LSB +: 3] = ou_stat_q;
			rd_d[`PGES_CU_STAT_LSB +: 2] = cu_stat_q;
		end else if (hit(reg_addr, `PGES_CTRL_STATUS_OFS)) begin
			rd_d[`PGES_CS_OUT_SEL_BIT] = out_sel_q[pin_ptr_q];
			rd_d[`PGES_CS_PIN_IN_BIT]  = pin_sync[pin_ptr_q];
			rd_d[`PGES_CS_DIR_BIT]     = pin_dir_q[pin_ptr_q];
			rd_d[`PGES_CS_CU_IRQ_BIT]  = cu_irq_en_q[cu_ptr_q];
			rd_d[`PGES_CS_OU_ACT_BIT]  = |(ou_active & ou_sel);
		end else if (hit(reg_addr, `PGES_IRQ_ENABLE_OFS)) begin
			rd_d[`PGES_OU_STAT_LSB +: 3] = irq_en_q[4:2];
			rd_d[`PGES_CU_STAT_LSB +: 2] = irq_en_q[1:0];
		end else if (hit(reg_addr, `PGES_OU_ENABLE_OFS)) begin
			rd_d[`PGES_EN_OU_NOTIFY_LSB +: 3] = ou_notify_q;
			rd_d[`PGES_EN_OU_RUN_LSB +: 3]    = ou_run_q;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			reg_rdata <= 32'h0000_0000;
		end else begin
			reg_rdata <= reg_rd ? rd_d : 32'h0000_0000;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	sequence s_ou_evt(int i);
		ou_event[i] && ou_notify_q[i];
	endsequence

	property p_irq_or;
		@(posedge sys_clk) disable iff (!nrst)
		1'b1 |=> irq == |(stat_all & $past(irq_en_q));
	endproperty
	a_irq_or: assert property (p_irq_or) else $error("summary irq not OR of flags");

	property p_ou_set;
		@(posedge sys_clk) disable iff (!nrst) s_ou_evt(0) |=> ou_stat_q[0];
	endproperty
	a_ou_set: assert property (p_ou_set) else $error("output flag not set");

	property p_ou_gate;
		@(posedge sys_clk) disable iff (!nrst)
		(!ou_notify_q[1] && !ou_stat_q[1]) |=> !ou_stat_q[1];
	endproperty
	a_ou_gate: assert property (p_ou_gate) else $error("output flag set while disabled");

	property p_cu_gate;
		@(posedge sys_clk) disable iff (!nrst)
		(cu_pin_event[0] && cu_irq_en_q[0]) |=> cu_stat_q[0];
	endproperty
	a_cu_gate: assert property (p_cu_gate) else $error("capture flag not set");

	property p_cu_off;
		@(posedge sys_clk) disable iff (!nrst)
		(!cu_irq_en_q[1] && !cu_stat_q[1]) |=> !cu_stat_q[1];
	endproperty
	a_cu_off: assert property (p_cu_off) else $error("capture flag set while disabled");

	property p_clr;
		@(posedge sys_clk) disable iff (!nrst)
		(wr_clr && reg_wdata[0] && !cu_set[0]) |=> !cu_stat_q[0];
	endproperty
	a_clr: assert property (p_clr) else $error("write one did not clear");

	property p_dir;
		@(posedge sys_clk) disable iff (!nrst)
		1'b1 |=> pin_oe == ~$past(pin_dir_q);
	endproperty
	a_dir: assert property (p_dir) else $error("pin direction mismatch");

	property p_rd;
		@(posedge sys_clk) disable iff (!nrst)
		(reg_rd && hit(reg_addr, `PGES_CTRL_STATUS_OFS) && ou_ptr_q == 2'h3)
		|=> !reg_rdata[`PGES_CS_OU_ACT_BIT];
	endproperty
	a_rd: assert property (p_rd) else $error("reserved pointer reads active");
endmodule
`default_nettype wire

// ### pges_bank_test.sv
// Self-checking testbench of the event pin status and control bank.
// Assumes pges_pkg and pges_regs.svh are compiled ahead of this file.
`timescale 1ns/10ps
`default_nettype none
`include "pges_regs.svh"

module pges_bank_test;
	import pges_pkg::*;

	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic          sys_clk;
	logic          nrst;
	pges_addr_type reg_addr;
	pges_word_type reg_wdata;
	logic          reg_wr;
	logic          reg_rd;
	pges_word_type reg_rdata;
	logic [2:0]    ou_fire;
	logic [2:0]    ou_late;
	logic [1:0]    cu_pin_event;
	logic [1:0]    pin_in;
	logic [1:0]    ou_pin_level;
	logic [1:0]    pin_out;
	logic [1:0]    pin_oe;
	logic          irq;
	int            bad_count;
	int            check_count;
	int            cycles;
	pges_word_type rv;

	pges_bank dut (
		.sys_clk      (sys_clk),
		.nrst         (nrst),
		.reg_addr     (reg_addr),
		.reg_wdata    (reg_wdata),
		.reg_wr       (reg_wr),
		.reg_rd       (reg_rd),
		.reg_rdata    (reg_rdata),
		.ou_fire      (ou_fire),
		.ou_late      (ou_late),
		.cu_pin_event (cu_pin_event),
		.pin_in       (pin_in),
		.ou_pin_level (ou_pin_level),
		.pin_out      (pin_out),
		.pin_oe       (pin_oe),
		.irq          (irq)
	);

	always #4 sys_clk = ~sys_clk;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic final_report();
		if (bad_count == 0 && check_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// Generous ceiling; the whole run needs under two hundred cycles
	always @(posedge sys_clk) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			bad_count++;
			final_report();
		end
	end

	task automatic chk(input string name, input pges_word_type exp, input pges_word_type got);
		check_count++;
		if (got !== exp) begin
			$display("mismatch %s expected %h seen %h", name, exp, got);
			bad_count++;
		end
	endtask

	task automatic wr(input pges_addr_type a, input pges_word_type d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input pges_addr_type a, output pges_word_type d);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		d = reg_rdata;
	endtask

	// One-cycle event pulses, sampled after the taking edge settles
	task automatic ev(input logic [2:0] f, input logic [2:0] l, input logic [1:0] c);
		@(posedge sys_clk);
		ou_fire      <= f;
		ou_late      <= l;
		cu_pin_event <= c;
		@(posedge sys_clk);
		ou_fire      <= 3'h0;
		ou_late      <= 3'h0;
		cu_pin_event <= 2'h0;
		@(negedge sys_clk);
	endtask

	task automatic idle(input int n);
		repeat (n) @(negedge sys_clk);
	endtask

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_reset();
		rd(`PGES_IRQ_STATUS_OFS, rv); chk("status", 32'h0000_0000, rv);
		rd(`PGES_IRQ_ENABLE_OFS, rv); chk("irq_enable", 32'h0007_0003, rv);
		rd(`PGES_CTRL_STATUS_OFS, rv); chk("ctrl", 32'h0000_0000, rv & 32'hFFFF_FF7F);
		chk("pin_oe", 32'h0000_0003, {30'h0, pin_oe});
		chk("irq", 32'h0000_0000, {31'h0, irq});
		wr(12'h530, 32'hFFFF_FFFF);
		rd(12'h530, rv); chk("unmapped", 32'h0000_0000, rv);
		wr(`PGES_UNIT_INDEX_OFS, 32'hFFFF_FFFF);
		rd(`PGES_UNIT_INDEX_OFS, rv); chk("index", 32'h0001_0103, rv);
	endtask

	task automatic t_capture();
		wr(`PGES_UNIT_INDEX_OFS, 32'h0000_0000);
		wr(`PGES_CTRL_STATUS_OFS, 32'h0000_0020);
		ev(3'h0, 3'h0, 2'h3);
		chk("irq", 32'h0000_0001, {31'h0, irq});
		rd(`PGES_IRQ_STATUS_OFS, rv); chk("status", 32'h0000_0001, rv);
		wr(`PGES_IRQ_STATUS_OFS, 32'h0000_0000);
		rd(`PGES_IRQ_STATUS_OFS, rv); chk("status", 32'h0000_0001, rv);
		// Masking keeps the flag but drops the line
		wr(`PGES_IRQ_ENABLE_OFS, 32'h0000_0000);
		idle(2); chk("irq", 32'h0000_0000, {31'h0, irq});
		wr(`PGES_IRQ_ENABLE_OFS, 32'h0007_0003);
		idle(2); chk("irq", 32'h0000_0001, {31'h0, irq});
		wr(`PGES_IRQ_STATUS_OFS, 32'h0000_0001);
		idle(2); chk("irq", 32'h0000_0000, {31'h0, irq});
		rd(`PGES_IRQ_STATUS_OFS, rv); chk("status", 32'h0000_0000, rv);
		ev(3'h0, 3'h0, 2'h1);
		wr(`PGES_IRQ_CLEAR_OFS, 32'h0000_0001);
		rd(`PGES_IRQ_STATUS_OFS, rv); chk("status", 32'h0000_0000, rv);
	endtask

	task automatic t_output();
		// Request enable on units 0 and 2, all three running
		wr(`PGES_OU_ENABLE_OFS, 32'h0000_0075);
		rd(`PGES_CTRL_STATUS_OFS, rv); chk("active0", 32'h0000_0010, rv & 32'h0000_0010);
		wr(`PGES_UNIT_INDEX_OFS, 32'h0000_0003);
		rd(`PGES_CTRL_STATUS_OFS, rv); chk("active3", 32'h0000_0000, rv & 32'h0000_0010);
		ev(3'h3, 3'h4, 2'h0);
		// Unit event pulse is flopped once more before the flag
		idle(1); chk("irq", 32'h0000_0001, {31'h0, irq});
		rd(`PGES_IRQ_STATUS_OFS, rv); chk("status", 32'h0005_0000, rv);
		// Restart unit 1 alone; only its pointer may read active
		wr(`PGES_OU_ENABLE_OFS, 32'h0000_0025);
		for (int u = 0; u < 3; u++) begin
			wr(`PGES_UNIT_INDEX_OFS, 32'(u));
			rd(`PGES_CTRL_STATUS_OFS, rv);
			chk("active", (u == 1) ? 32'h0000_0010 : 32'h0000_0000, rv & 32'h0000_0010);
		end
		wr(`PGES_IRQ_STATUS_OFS, 32'h0007_0003);
		rd(`PGES_IRQ_STATUS_OFS, rv); chk("status", 32'h0000_0000, rv);
	endtask

	task automatic t_pin();
		wr(`PGES_UNIT_INDEX_OFS, 32'h0001_0000);
		wr(`PGES_CTRL_STATUS_OFS, 32'h0000_0060);
		idle(2); chk("pin_oe", 32'h0000_0001, {30'h0, pin_oe});
		rd(`PGES_CTRL_STATUS_OFS, rv); chk("pin1", 32'h0000_00C0, rv & 32'h0000_01C0);
		wr(`PGES_UNIT_INDEX_OFS, 32'h0000_0000);
		// Swap the pin levels; allow the two synchroniser stages
		@(posedge sys_clk);
		pin_in <= 2'h1;
		idle(3);
		rd(`PGES_CTRL_STATUS_OFS, rv); chk("pin0", 32'h0000_0080, rv & 32'h0000_01C0);
		// Direct source: one flop to the pin
		wr(`PGES_CTRL_STATUS_OFS, 32'h0000_0120);
		@(posedge sys_clk);
		ou_pin_level <= 2'h1;
		idle(2); chk("pin_out", 32'h0000_0001, {31'h0, pin_out[0]});
		// Flopped source: one more cycle of delay
		wr(`PGES_CTRL_STATUS_OFS, 32'h0000_0020);
		@(posedge sys_clk);
		ou_pin_level <= 2'h0;
		idle(2); chk("pin_out", 32'h0000_0001, {31'h0, pin_out[0]});
		idle(1); chk("pin_out", 32'h0000_0000, {31'h0, pin_out[0]});
	endtask

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		sys_clk      = 1'b0;
		nrst         = 1'b0;
		reg_addr     = 12'h000;
		reg_wdata    = 32'h0000_0000;
		reg_wr       = 1'b0;
		reg_rd       = 1'b0;
		ou_fire      = 3'h0;
		ou_late      = 3'h0;
		cu_pin_event = 2'h0;
		pin_in       = 2'h2;
		ou_pin_level = 2'h0;
		bad_count    = 0;
		check_count  = 0;
		cycles       = 0;
		repeat (16) @(posedge sys_clk);
		nrst <= 1'b1;
		t_reset();
		t_capture();
		t_output();
		t_pin();
		final_report();
	end
endmodule

`default_nettype wire
